// >>> src/vcp_top.sv
// Colour conversion, SD scaling, hue and brightness for a video encoder.
// Assumes pixels and register accesses come from logic on ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "vcp_params.svh"

// ----------------------------------------------------------------------
// Pixel FIFO
// ----------------------------------------------------------------------
module vcp_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 8
) (
	// Clocking
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	// Fill side
	input  wire logic             push_valid_in,
	output var  logic             push_ready_out,
	input  wire logic [WIDTH-1:0] push_data_in,
	// Drain side
	output var  logic             pop_valid_out,
	input  wire logic             pop_ready_in,
	output var  logic [WIDTH-1:0] pop_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             do_push;
	logic             do_pop;
	logic [AW:0]      next_count;

	// Handshakes; ready is a flop so the top output is registered
	assign do_push = ce_in && push_valid_in && push_ready_out;
	assign do_pop  = ce_in && pop_valid_out && pop_ready_in;
	assign next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
	assign pop_valid_out = (count != '0);
	assign pop_data_out  = mem[rd_ptr];

	// Storage
	always_ff @(posedge clk_in) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data_in;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr         <= '0;
			rd_ptr         <= '0;
			count          <= '0;
			push_ready_out <= 1'b0;
		end else if (ce_in) begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count          <= next_count;
			push_ready_out <= (next_count < (AW+1)'(DEPTH));
		end
	end
endmodule : vcp_fifo

// ----------------------------------------------------------------------
// Top: registers and datapath
// ----------------------------------------------------------------------
module vcp_top #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock, reset, enable
	input  wire logic               ref_clk_in,
	input  wire logic               rst_in,
	input  wire logic               ce_in,
	// Register port
	input  wire logic               reg_wr_en_in,
	input  wire logic               reg_rd_en_in,
	input  wire logic [7:0]         reg_addr_in,
	input  wire logic [7:0]         reg_wdata_in,
	output var  logic [7:0]         reg_rdata_out,
	// Pixel input: c0 Y/G, c1 Cb/B, c2 Cr/R
	input  wire logic               pix_valid_in,
	output var  logic               pix_ready_out,
	input  wire logic [7:0]         pix_c0_in,
	input  wire logic [7:0]         pix_c1_in,
	input  wire logic [7:0]         pix_c2_in,
	input  wire logic               pix_active_in,
	input  wire logic               test_pattern_in,
	input  wire logic               pal_in,
	// Pixel output: c0 Y/G, c1 Pb/B, c2 Pr/R
	output var  logic               out_valid_out,
	input  wire logic               out_ready_in,
	output var  vcp_pkg::vcp_code_t out_c0_out,
	output var  vcp_pkg::vcp_code_t out_c1_out,
	output var  vcp_pkg::vcp_code_t out_c2_out,
	output var  logic signed [8:0]  hue_shift_out
);
	import vcp_pkg::*;

	// Register file
	vcp_byte_t mode_select, output_ctrl, edhd_input, sd_feature;
	vcp_byte_t matrix_luma_coeff_low, matrix_coeff_low_bits;
	vcp_byte_t matrix_luma_coeff_high, matrix_green_pb_coeff_high;
	vcp_byte_t matrix_green_pr_coeff_high, matrix_blue_pb_coeff_high;
	vcp_byte_t matrix_red_pr_coeff_high, sd_scale_low_bits;
	vcp_byte_t sd_luma_scale, sd_blue_diff_scale, sd_red_diff_scale;
	vcp_byte_t sd_hue_shift, sd_brightness_setup, sd_brightness_monitor;

	// FIFO wires
	logic        fifo_valid;
	logic        fifo_take;
	logic [26:0] fifo_data;
	logic [7:0]  c0, c1, c2;
	logic        f_active, f_test, f_pal;

	// Datapath results
	vcp_code_t         next_c0, next_c1, next_c2;
	logic signed [8:0] next_hue;
	logic              sd_mode;

	// Rounded reciprocal-of-315 product, so no divider is needed
	function automatic logic signed [31:0] matrix_term(
		input logic        ch_rgb,
		input logic [1:0]  ch,
		input logic signed [31:0] y,
		input logic signed [31:0] pb,
		input logic signed [31:0] pr,
		input vcp_coeff_t  gy, gu, gv, bu, rv
	);
		logic signed [31:0] acc;
		logic signed [31:0] gys, gus, gvs, bus, rvs;
		gys = $signed({22'd0, gy});
		gus = $signed({22'd0, gu});
		gvs = $signed({22'd0, gv});
		bus = $signed({22'd0, bu});
		rvs = $signed({22'd0, rv});
		if (ch_rgb) begin
			unique case (ch)
				2'd0:    acc = gys*y - gus*pb - gvs*pr;
				2'd1:    acc = gys*y + bus*pb;
				default: acc = gys*y + rvs*pr;
			endcase
		end else begin
			unique case (ch)
				2'd0:    acc = gys*y;
				2'd1:    acc = bus*pb;
				default: acc = rvs*pr;
			endcase
		end
		// Scale back by 315 with rounding
		acc = (acc*`VCP_RECIP_315 + (32'sd1 <<< (`VCP_RECIP_SHIFT-1)))
			>>> `VCP_RECIP_SHIFT;
		if (!ch_rgb && ch != 2'd0) begin
			acc = acc + `VCP_DIFF_MID;
		end
		return acc;
	endfunction : matrix_term

	// Saturate to the ten-bit code range instead of wrapping
	function automatic vcp_code_t clip10(input logic signed [31:0] v);
		if (v < 0) begin
			return '0;
		end else if (v > `VCP_CODE_MAX) begin
			return 10'h3FF;
		end
		return v[9:0];
	endfunction : clip10

	// Ten-bit scale factor with rounding, 512 meaning unity
	function automatic logic signed [31:0] scale(
		input logic signed [31:0] v,
		input logic [9:0]         k
	);
		return (v*$signed({22'd0, k}) + 32'sd256) >>> `VCP_SCALE_SHIFT;
	endfunction : scale

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			mode_select                <= 8'h00;
			output_ctrl                <= 8'h00;
			edhd_input                 <= 8'h00;
			sd_feature                 <= 8'h00;
			matrix_luma_coeff_low      <= `VCP_LUMA_LOW_RST;
			matrix_coeff_low_bits      <= `VCP_COEFF_LOW_RST;
			matrix_luma_coeff_high     <= `VCP_LUMA_HIGH_RST;
			matrix_green_pb_coeff_high <= `VCP_GREEN_PB_RST;
			matrix_green_pr_coeff_high <= `VCP_GREEN_PR_RST;
			matrix_blue_pb_coeff_high  <= `VCP_BLUE_PB_RST;
			matrix_red_pr_coeff_high   <= `VCP_RED_PR_RST;
			sd_scale_low_bits          <= 8'h00;
			sd_luma_scale              <= `VCP_SCALE_HIGH_RST;
			sd_blue_diff_scale         <= `VCP_SCALE_HIGH_RST;
			sd_red_diff_scale          <= `VCP_SCALE_HIGH_RST;
			sd_hue_shift               <= `VCP_HUE_RST;
			sd_brightness_setup        <= 8'h00;
		end else if (ce_in && reg_wr_en_in) begin
			unique case (reg_addr_in)
				`VCP_MODE_SELECT_OFS: mode_select                <= reg_wdata_in;
				`VCP_OUTPUT_CTRL_OFS: output_ctrl                <= reg_wdata_in;
				`VCP_EDHD_INPUT_OFS:  edhd_input                 <= reg_wdata_in;
				`VCP_SD_FEATURE_OFS:  sd_feature                 <= reg_wdata_in;
				`VCP_LUMA_LOW_OFS:    matrix_luma_coeff_low      <= reg_wdata_in;
				`VCP_COEFF_LOW_OFS:   matrix_coeff_low_bits      <= reg_wdata_in;
				`VCP_LUMA_HIGH_OFS:   matrix_luma_coeff_high     <= reg_wdata_in;
				`VCP_GREEN_PB_OFS:    matrix_green_pb_coeff_high <= reg_wdata_in;
				`VCP_GREEN_PR_OFS:    matrix_green_pr_coeff_high <= reg_wdata_in;
				`VCP_BLUE_PB_OFS:     matrix_blue_pb_coeff_high  <= reg_wdata_in;
				`VCP_RED_PR_OFS:      matrix_red_pr_coeff_high   <= reg_wdata_in;
				`VCP_SCALE_LOW_OFS:   sd_scale_low_bits          <= reg_wdata_in;
				`VCP_LUMA_SCALE_OFS:  sd_luma_scale              <= reg_wdata_in;
				`VCP_BLUE_SCALE_OFS:  sd_blue_diff_scale         <= reg_wdata_in;
				`VCP_RED_SCALE_OFS:   sd_red_diff_scale          <= reg_wdata_in;
				`VCP_HUE_OFS:         sd_hue_shift               <= reg_wdata_in;
				`VCP_BRIGHT_OFS:      sd_brightness_setup        <= reg_wdata_in;
				default: ;  // Monitor and unmapped offsets ignore writes
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Register reads, one cycle after the strobe; unmapped reads zero
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (ce_in && reg_rd_en_in) begin
			unique case (reg_addr_in)
				`VCP_MODE_SELECT_OFS: reg_rdata_out <= mode_select;
				`VCP_OUTPUT_CTRL_OFS: reg_rdata_out <= output_ctrl;
				`VCP_EDHD_INPUT_OFS:  reg_rdata_out <= edhd_input;
				`VCP_SD_FEATURE_OFS:  reg_rdata_out <= sd_feature;
				`VCP_LUMA_LOW_OFS:    reg_rdata_out <= matrix_luma_coeff_low;
				`VCP_COEFF_LOW_OFS:   reg_rdata_out <= matrix_coeff_low_bits;
				`VCP_LUMA_HIGH_OFS:   reg_rdata_out <= matrix_luma_coeff_high;
				`VCP_GREEN_PB_OFS:  reg_rdata_out <= matrix_green_pb_coeff_high;
				`VCP_GREEN_PR_OFS:  reg_rdata_out <= matrix_green_pr_coeff_high;
				`VCP_BLUE_PB_OFS:   reg_rdata_out <= matrix_blue_pb_coeff_high;
				`VCP_RED_PR_OFS:    reg_rdata_out <= matrix_red_pr_coeff_high;
				`VCP_SCALE_LOW_OFS:   reg_rdata_out <= sd_scale_low_bits;
				`VCP_LUMA_SCALE_OFS:  reg_rdata_out <= sd_luma_scale;
				`VCP_BLUE_SCALE_OFS:  reg_rdata_out <= sd_blue_diff_scale;
				`VCP_RED_SCALE_OFS:   reg_rdata_out <= sd_red_diff_scale;
				`VCP_HUE_OFS:         reg_rdata_out <= sd_hue_shift;
				`VCP_BRIGHT_OFS:      reg_rdata_out <= sd_brightness_setup;
				`VCP_MONITOR_OFS:  reg_rdata_out <= sd_brightness_monitor;
				default:              reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Input buffer; the output stage stalls it under back-pressure
	// ------------------------------------------------------------------
	vcp_fifo #(
		.WIDTH (27),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in         (ref_clk_in),
		.rst_in         (rst_in),
		.ce_in          (ce_in),
		.push_valid_in  (pix_valid_in),
		.push_ready_out (pix_ready_out),
		.push_data_in   ({test_pattern_in, pal_in, pix_active_in,
			pix_c2_in, pix_c1_in, pix_c0_in}),
		.pop_valid_out  (fifo_valid),
		.pop_ready_in   (fifo_take),
		.pop_data_out   (fifo_data)
	);
	assign {f_test, f_pal, f_active, c2, c1, c0} = fifo_data;
	assign fifo_take = !out_valid_out || out_ready_in;
	// Mode field zero selects SD, anything else ED/HD
	assign sd_mode = (mode_select[`VCP_MODE_MSB:`VCP_MODE_LSB] == 3'd0);

	// ------------------------------------------------------------------
	// Conversion datapath
	// ------------------------------------------------------------------
	always_comb begin
		logic               rgb_out, rgb_in, manual;
		logic signed [31:0] y, pb, pr, r, g, b, bright, o0, o1, o2;
		vcp_coeff_t         gy, gu, gv, bu, rv;
		logic [7:0]         hue_code;
		rgb_out = !output_ctrl[`VCP_OUT_YPRPB_BIT];
		manual  = output_ctrl[`VCP_MANUAL_BIT] && !sd_mode;
		rgb_in  = sd_mode ? sd_feature[`VCP_SD_RGB_IN_BIT]
			: edhd_input[`VCP_EDHD_RGB_IN_BIT];
		// Ten-bit coefficients from high byte and low pair
		gy = {matrix_luma_coeff_high,      matrix_luma_coeff_low[1:0]};
		gu = {matrix_green_pb_coeff_high,  matrix_coeff_low_bits[7:6]};
		gv = {matrix_green_pr_coeff_high,  matrix_coeff_low_bits[5:4]};
		bu = {matrix_blue_pb_coeff_high,   matrix_coeff_low_bits[3:2]};
		rv = {matrix_red_pr_coeff_high,    matrix_coeff_low_bits[1:0]};
		// Automatic path and test patterns use fixed HD factors
		if (!manual || f_test) begin
			gy = {`VCP_LUMA_HIGH_RST, 2'b11};
			gu = {`VCP_GREEN_PB_RST, 2'b11};
			gv = {`VCP_GREEN_PR_RST, 2'b11};
			bu = {`VCP_BLUE_PB_RST,  2'b00};
			rv = {`VCP_RED_PR_RST,   2'b00};
		end
		r = $signed({22'd0, c2, 2'b00});
		g = $signed({22'd0, c0, 2'b00});
		b = $signed({22'd0, c1, 2'b00});
		y  = g;
		pb = b - `VCP_DIFF_MID;
		pr = r - `VCP_DIFF_MID;
		o0 = g;
		o1 = b;
		o2 = r;
		bright = 0;
		if (sd_mode) begin
			// RGB input goes to luma and differences first
			if (rgb_in) begin
				y  = (32'sd77*r + 32'sd150*g + 32'sd29*b + 32'sd128) >>> 8;
				pb = (32'sd128*b - 32'sd43*r - 32'sd85*g + 32'sd128) >>> 8;
				pr = (32'sd128*r - 32'sd107*g - 32'sd21*b + 32'sd128) >>> 8;
			end
			// Scales apply ahead of every SD output
			y  = scale(y, {sd_luma_scale, sd_scale_low_bits[1:0]});
			pb = scale(pb, {sd_blue_diff_scale, sd_scale_low_bits[3:2]});
			pr = scale(pr, {sd_red_diff_scale, sd_scale_low_bits[5:4]});
			// Seven-bit signed setup code on scaled luma
			if (sd_feature[`VCP_BRIGHT_EN_BIT]) begin
				bright = $signed({{25{sd_brightness_setup[6]}},
					sd_brightness_setup[6:0]}) <<< 1;
			end
			y = y + bright;
			if (rgb_out) begin
				o0 = matrix_term(1'b1, 2'd0, y, pb, pr, gy, gu, gv, bu, rv);
				o1 = matrix_term(1'b1, 2'd1, y, pb, pr, gy, gu, gv, bu, rv);
				o2 = matrix_term(1'b1, 2'd2, y, pb, pr, gy, gu, gv, bu, rv);
			end else begin
				o0 = y;
				o1 = pb + `VCP_DIFF_MID;
				o2 = pr + `VCP_DIFF_MID;
			end
		end else if (!rgb_in && (rgb_out || manual)) begin
			// YPrPb output with RGB input stays RGB
			o0 = matrix_term(rgb_out, 2'd0, y, pb, pr, gy, gu, gv, bu, rv);
			o1 = matrix_term(rgb_out, 2'd1, y, pb, pr, gy, gu, gv, bu, rv);
			o2 = matrix_term(rgb_out, 2'd2, y, pb, pr, gy, gu, gv, bu, rv);
		end
		next_c0 = clip10(o0);
		next_c1 = clip10(o1);
		next_c2 = clip10(o2);
		// Phase step code; PAL floor is one code up
		hue_code = (f_pal && sd_hue_shift == 8'h00) ? 8'h01 : sd_hue_shift;
		next_hue = '0;
		if (sd_mode && f_active && sd_feature[`VCP_HUE_EN_BIT]) begin
			next_hue = $signed({1'b0, hue_code}) - `VCP_HUE_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Output stage; holds its word until the sink takes it
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			out_valid_out <= 1'b0;
			out_c0_out    <= '0;
			out_c1_out    <= '0;
			out_c2_out    <= '0;
			hue_shift_out <= '0;
		end else if (ce_in && fifo_take) begin
			out_valid_out <= fifo_valid;
			if (fifo_valid) begin
				out_c0_out    <= next_c0;
				out_c1_out    <= next_c1;
				out_c2_out    <= next_c2;
				hue_shift_out <= next_hue;
			end
		end
	end

	// ------------------------------------------------------------------
	// Brightness monitor: leaky average of incoming SD c0 (Y, or G with RGB input)
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sd_brightness_monitor <= 8'h00;
		end else if (ce_in && fifo_valid && fifo_take && sd_mode) begin
			// Averaging over 16 pixels trades latency for a steady reading
			sd_brightness_monitor <= 8'((({4'd0, sd_brightness_monitor} * 12'd15)
				+ {4'd0, c0} + 12'd8) >> 4);
		end
	end
endmodule : vcp_top
`default_nettype wire

// >>> src/vcp_params.svh
// Constants of the video colour processing block: offsets, fields, resets.
// Included by the package and the datapath; holds definitions only.
`ifndef VCP_PARAMS_SVH
`define VCP_PARAMS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define VCP_MODE_SELECT_OFS     8'h01
`define VCP_OUTPUT_CTRL_OFS     8'h02
`define VCP_LUMA_LOW_OFS        8'h03
`define VCP_COEFF_LOW_OFS       8'h04
`define VCP_LUMA_HIGH_OFS       8'h05
`define VCP_GREEN_PB_OFS        8'h06
`define VCP_GREEN_PR_OFS        8'h07
`define VCP_BLUE_PB_OFS         8'h08
`define VCP_RED_PR_OFS          8'h09
`define VCP_EDHD_INPUT_OFS      8'h35
`define VCP_SD_FEATURE_OFS      8'h87
`define VCP_SCALE_LOW_OFS       8'h9C
`define VCP_LUMA_SCALE_OFS      8'h9D
`define VCP_BLUE_SCALE_OFS      8'h9E
`define VCP_RED_SCALE_OFS       8'h9F
`define VCP_HUE_OFS             8'hA0
`define VCP_BRIGHT_OFS          8'hA1
`define VCP_MONITOR_OFS         8'hBA
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VCP_MODE_MSB            6
`define VCP_MODE_LSB            4
`define VCP_OUT_YPRPB_BIT       5
`define VCP_MANUAL_BIT          3
`define VCP_EDHD_RGB_IN_BIT     1
`define VCP_SD_RGB_IN_BIT       7
`define VCP_BRIGHT_EN_BIT       3
`define VCP_HUE_EN_BIT          2
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VCP_LUMA_LOW_RST        8'h03
`define VCP_COEFF_LOW_RST       8'hF0
`define VCP_LUMA_HIGH_RST       8'h4E
`define VCP_GREEN_PB_RST        8'h0E
`define VCP_GREEN_PR_RST        8'h24
`define VCP_BLUE_PB_RST         8'h92
`define VCP_RED_PR_RST          8'h7C
`define VCP_SCALE_HIGH_RST      8'h80
`define VCP_HUE_RST             8'h80
// ----------------------------------------------------------------------
// Arithmetic constants
// ----------------------------------------------------------------------
`define VCP_RECIP_315           32'sd208
`define VCP_RECIP_SHIFT         16
`define VCP_SCALE_SHIFT         9
`define VCP_HUE_ZERO            9'sd128
`define VCP_DIFF_MID            32'sd512
`define VCP_CODE_MAX            32'sd1023
`endif

// >>> src/vcp_pkg.sv
// Types shared by the video colour processing block.
// Assumes vcp_params.svh is on the include path.
`include "vcp_params.svh"
package vcp_pkg;
	typedef logic [9:0] vcp_code_t;
	typedef logic [7:0] vcp_byte_t;
	typedef logic [9:0] vcp_coeff_t;
endpackage : vcp_pkg

// >>> test/vcp_monitor.sv
// Port checker for the colour processing block, bound to vcp_top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module vcp_monitor (
	// Watched ports
	input wire logic               ref_clk_in,
	input wire logic               rst_in,
	input wire logic               ce_in,
	input wire logic               reg_wr_en_in,
	input wire logic               reg_rd_en_in,
	input wire logic [7:0]         reg_addr_in,
	input wire logic [7:0]         reg_wdata_in,
	input wire logic [7:0]         reg_rdata_out,
	input wire logic               pix_valid_in,
	input wire logic               pix_ready_out,
	input wire logic               out_valid_out,
	input wire logic               out_ready_in,
	input wire vcp_pkg::vcp_code_t out_c0_out,
	input wire logic signed [8:0]  hue_shift_out
);
	import vcp_pkg::*;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	logic       hue_on;
	logic [2:0] mode;
	logic [3:0] drained;
	wire        cfg_wr = ce_in && reg_wr_en_in &&
		(reg_addr_in == 8'h01 || reg_addr_in == 8'h87);
	function automatic logic rw(input logic [7:0] a);
		return a inside {[8'h01:8'h09], 8'h35, 8'h87, [8'h9C:8'hA1]};
	endfunction : rw
	// Shadow of mode and hue enable; ten outputs after a change
	// flush pixels still converted under the old settings
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			hue_on <= 1'b0;
			mode <= 3'h0;
			drained <= 4'h0;
		end else if (cfg_wr) begin
			drained <= 4'h0;
			if (reg_addr_in == 8'h01)
				mode <= reg_wdata_in[6:4];
			else
				hue_on <= reg_wdata_in[2];
		end else if (ce_in && out_valid_out && out_ready_in && drained != 4'hA)
			drained <= drained + 4'h1;
	end
	sequence take_s;
		ce_in && pix_valid_in && pix_ready_out;
	endsequence
	sequence wr_rd_s;
		ce_in && reg_wr_en_in && rw(reg_addr_in) ##1 !(ce_in && reg_wr_en_in)
		##1 ce_in && reg_rd_en_in && !reg_wr_en_in
		&& reg_addr_in == $past(reg_addr_in, 2);
	endsequence
	rst_clear_a: assert property ($fell(rst_in) |-> !out_valid_out
		&& !pix_ready_out && reg_rdata_out == 8'h00)
		else $error("outputs not cleared by reset");
	read_back_a: assert property (wr_rd_s |=>
		reg_rdata_out == $past(reg_wdata_in, 3))
		else $error("register read back differs from write");
	unmapped_zero_a: assert property (ce_in && reg_rd_en_in
		&& !rw(reg_addr_in) && reg_addr_in != 8'hBA |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!(ce_in && reg_rd_en_in)
		|=> $stable(reg_rdata_out)) else $error("read data moved");
	ce_freeze_a: assert property (!ce_in |=> $stable(out_valid_out)
		&& $stable(pix_ready_out) && $stable(out_c0_out))
		else $error("state moved with enable low");
	take_out_a: assert property (take_s |-> ##[1:4] out_valid_out)
		else $error("taken pixel never reached output");
	out_hold_a: assert property (out_valid_out && !out_ready_in
		|=> out_valid_out && $stable(out_c0_out) && $stable(hue_shift_out))
		else $error("stalled output changed");
	hue_off_a: assert property (out_valid_out && drained == 4'hA
		&& (!hue_on || mode != 3'h0) |-> hue_shift_out == 9'sh0)
		else $error("hue shift without SD hue enable");
endmodule : vcp_monitor
bind vcp_top vcp_monitor i_mon (.ref_clk_in, .rst_in, .ce_in, .reg_wr_en_in,
	.reg_rd_en_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .pix_valid_in,
	.pix_ready_out, .out_valid_out, .out_ready_in, .out_c0_out, .hue_shift_out);
`default_nettype wire

// >>> test/vcp_source.sv
// Model of the upstream pixel source feeding the block.
// Assumes ready_in already includes the clock enable.
`timescale 1ns/1ps
`default_nettype none
module vcp_source (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ready_in,
	output var  logic        valid_out,
	output var  logic [26:0] data_out
);
	logic [26:0] q[$];
	int          slow = 0;
	int          gap = 0;
	initial begin
		valid_out = 1'b0;
		data_out = 27'h0;
	end
	// Hold each pixel until taken; idle lines toggle so a sink
	// sampling without valid cannot see the last word by luck
	always @(posedge clk_in) begin
		if (!(valid_out && !ready_in)) begin
			if (valid_out)
				gap = slow;
			if (gap == 0 && !rst_in && q.size() != 0) begin
				valid_out <= 1'b1;
				data_out <= q.pop_front();
			end else begin
				valid_out <= 1'b0;
				data_out <= ~data_out;
				if (gap > 0)
					gap--;
			end
		end
	end
endmodule : vcp_source
`default_nettype wire

// >>> test/video_color_processing_bench.sv
// Self-checking bench for the colour processing block.
// Assumes the source model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module video_color_processing_bench;
	import vcp_pkg::*;
	logic clk = 0, rst = 1, ce = 1, we = 0, re = 0, ord = 1, pv, pr, ov;
	logic [7:0]  addr = 8'h00, wd = 8'h00, rdat;
	logic [26:0] pd;
	vcp_code_t   o0, o1, o2;
	logic signed [8:0] hs;
	int err_count = 0, compares = 0, cyc = 0, mon = 0;
	logic [38:0] got[$];
	logic [7:0]  rtab [7] = '{8'h03, 8'hF0, 8'h4E, 8'h0E, 8'h24, 8'h92, 8'h7C};
	logic [15:0] cfg [3] = '{16'h0200, 16'h0220, 16'h0020};
	logic [17:0] htab [4] = '{{9'h180, 1'b0, 8'h00}, {9'h181, 1'b1, 8'h00},
		{9'h07F, 1'b0, 8'hFF}, {9'h000, 1'b1, 8'h80}};
	vcp_top i_dut (.ref_clk_in(clk), .rst_in(rst), .ce_in(ce),
		.reg_wr_en_in(we), .reg_rd_en_in(re), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_rdata_out(rdat), .pix_valid_in(pv),
		.pix_ready_out(pr), .pix_c0_in(pd[7:0]), .pix_c1_in(pd[15:8]),
		.pix_c2_in(pd[23:16]), .pix_active_in(pd[24]),
		.test_pattern_in(pd[25]), .pal_in(pd[26]), .out_valid_out(ov),
		.out_ready_in(ord), .out_c0_out(o0), .out_c1_out(o1),
		.out_c2_out(o2), .hue_shift_out(hs));
	vcp_source i_src (.clk_in(clk), .rst_in(rst), .ready_in(pr && ce),
		.valid_out(pv), .data_out(pd));
	initial begin
		forever #5 clk = ~clk;
	end
	// Capture accepted outputs; cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (ov && ord && ce)
			got.push_back({hs, o0, o1, o2});
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic chkr(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chkr
	task automatic chkp(input logic [38:0] e);
		logic [38:0] g;
		int n;
		n = 0;
		while (got.size() == 0 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		g = (got.size() != 0) ? got.pop_front() : 39'hx;
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chkp
	// One register cycle: strobe for one edge, then release
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= w;
		re <= !w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		we <= 1'b0;
		re <= 1'b0;
		#1;
	endtask : bus
	task automatic rdr(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chkr(rdat, e);
	endtask : rdr
	task automatic sdpx(input logic [26:0] d, input logic [38:0] e);
		i_src.q.push_back(d);
		mon = (15 * mon + d[7:0] + 8) >> 4;
		chkp(e);
	endtask : sdpx
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rdr(8'h03 + 8'(i), rtab[i]);
		rdr(8'h02, 8'h00);
		bus(1'b1, 8'h10, 8'h5A);
		rdr(8'h10, 8'h00);
		// Read back a plain register; SD pixels below keep Cr at mid
		bus(1'b1, 8'h9F, 8'hA5);
		rdr(8'h9F, 8'hA5);
		$display("test registers done");
		// ED/HD automatic paths pass data through, slow source first
		bus(1'b1, 8'h01, 8'h10);
		for (int i = 0; i < 3; i++) begin
			i_src.slow = 2 - i;
			bus(1'b1, 8'h35, cfg[i][15:8]);
			bus(1'b1, 8'h02, cfg[i][7:0]);
			i_src.q.push_back(27'h0563412);
			chkp({9'h0, 10'h048, 10'h0D0, 10'h158});
		end
		// Fill the FIFO against a stalled sink, freeze, then drain
		@(posedge clk);
		ord <= 1'b0;
		for (int i = 0; i < 12; i++)
			i_src.q.push_back({19'h08080, 8'(i * 16)});
		for (int n = 0; n < 40 && pr; n++)
			@(posedge clk);
		chkr({7'h0, pr}, 8'h00);
		@(posedge clk);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		ord <= 1'b1;
		for (int i = 0; i < 12; i++)
			chkp({9'h0, 10'(i * 64), 10'h200, 10'h200});
		$display("test auto paths done");
		// Manual matrix; coefficients are factors times 315
		bus(1'b1, 8'h02, 8'h28);
		i_src.q.push_back(27'h0908064);
		chkp({9'h0, 10'h190, 10'h200, 10'h265});
		bus(1'b1, 8'h02, 8'h08);
		bus(1'b1, 8'h35, 8'h00);
		i_src.q.push_back(27'h0908064);
		chkp({9'h0, 10'h172, 10'h190, 10'h1F5});
		bus(1'b1, 8'h09, 8'h00);
		i_src.q.push_back(27'h0908064);
		chkp({9'h0, 10'h172, 10'h190, 10'h190});
		i_src.q.push_back(27'h2908064);
		chkp({9'h0, 10'h172, 10'h190, 10'h1F5});
		// Manual off: automatic RGB output ignores the cleared register
		bus(1'b1, 8'h02, 8'h00);
		i_src.q.push_back(27'h0908064);
		chkp({9'h0, 10'h172, 10'h190, 10'h1F5});
		$display("test manual matrix done");
		// SD scaling, brightness and hue
		bus(1'b1, 8'h01, 8'h00);
		bus(1'b1, 8'h02, 8'h20);
		bus(1'b1, 8'h87, 8'h0C);
		bus(1'b1, 8'h9C, 8'h01);
		bus(1'b1, 8'h9D, 8'h60);
		bus(1'b1, 8'h9E, 8'h40);
		bus(1'b1, 8'hA0, 8'h97);
		sdpx(27'h180C080, {9'h017, 10'h181, 10'h280, 10'h200});
		bus(1'b1, 8'h9C, 8'h00);
		bus(1'b1, 8'hA1, 8'h71);
		sdpx(27'h0808064, {9'h0, 10'h10E, 10'h200, 10'h200});
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'hA0, htab[i][7:0]);
			sdpx({htab[i][8], 2'b01, 24'h808064},
				{htab[i][17:9], 10'h10E, 10'h200, 10'h200});
		end
		bus(1'b1, 8'h87, 8'h08);
		bus(1'b1, 8'h9D, 8'h80);
		bus(1'b1, 8'hA1, 8'h1E);
		sdpx(27'h18080FF, {9'h0, 10'h3FF, 10'h200, 10'h200});
		// SD RGB output, then RGB input to YPrPb output
		bus(1'b1, 8'h02, 8'h00);
		sdpx(27'h0808064, {9'h0, 10'h1CC, 10'h1CC, 10'h1CC});
		bus(1'b1, 8'h02, 8'h20);
		bus(1'b1, 8'h87, 8'h88);
		sdpx(27'h0646464, {9'h0, 10'h1CC, 10'h200, 10'h200});
		bus(1'b1, 8'hBA, 8'h55);
		rdr(8'hBA, 8'(mon));
		$display("test sd path done");
		stop_test();
	end
endmodule : video_color_processing_bench
`default_nettype wire
